// ===== tb_uart_line_format.sv
`timescale 1ns/10ps
module tb_uart_line_format;
  reg        i_ref_clk = 1'b0;
  reg        i_rst     = 1'b1;
  reg        i_aen_n   = 1'b0;
  reg        i_rd      = 1'b0;
  reg        i_wr      = 1'b0;
  reg  [2:0] i_addr    = 3'h0;
  reg  [7:0] i_wdata   = 8'h00;
  reg  [3:0] nbits     = 4'h8;
  reg        par_en    = 1'b0;
  wire [7:0] o_rdata;
  wire       o_serial_output_pin;
  wire       o_baud_clock_output;
  wire       rx_line;
  integer    num_errors = 0;
  integer    checks_done = 0;
  integer    i, k, n0, nb, per;
  reg  [7:0] v, fmt, d;
  localparam [63:0] FMTS = 64'h00_04_05_0b_1a_2b_3a_0e;
  // 40 MHz device clock
  always #12.5 i_ref_clk = ~i_ref_clk;
  uart_line_format uart_line_format_i (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_aen_n(i_aen_n), .i_addr(i_addr), .i_rd(i_rd),
    .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_serial_in(rx_line), .o_serial_output_pin(o_serial_output_pin),
    .o_baud_clock_output(o_baud_clock_output));
  uart_serial_peer uart_serial_peer_i (.i_ref_clk(i_ref_clk),
    .i_line(o_serial_output_pin), .o_line(rx_line), .i_nbits(nbits),
    .i_par_en(par_en));
  task chk(input string what, input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] dv);
    begin
      @(posedge i_ref_clk);
      i_addr <= a; i_wdata <= dv; i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [2:0] a, output [7:0] dv);
    begin
      @(posedge i_ref_clk);
      i_addr <= a; i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 dv = o_rdata;
    end
  endtask
  task rc(input [2:0] a, input [7:0] e, input string w);
    begin
      rd(a, v);
      chk(w, v, e);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // count baud output toggles over 40 device clock cycles
  task toggles(output integer t);
    begin
      t = 0;
      repeat (40) begin
        v[0] = o_baud_clock_output;
        @(posedge i_ref_clk); #1;
        if (o_baud_clock_output !== v[0]) t = t + 1;
      end
    end
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rc(3'h3, 8'h00, "line format");
    rc(3'h2, 8'h01, "ident");
    rc(3'h5, 8'h60, "line status");
    rc(3'h6, 8'h00, "modem status");
    $display("test reset values done");
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h02);
    wr(3'h1, 8'h00);
    rc(3'h0, 8'h02, "divisor low");
    toggles(k);
    chk("baud running", k != 0, 1'b1);
    // back to divisor one, which the serial tests assume
    wr(3'h0, 8'h01);
    wr(3'h3, 8'h03);
    wr(3'h1, 8'h0f);
    rc(3'h1, 8'h0f, "int enable");
    toggles(k);
    chk("baud gated", k, 0);
    wr(3'h3, 8'h83);
    rc(3'h1, 8'h00, "divisor high");
    wr(3'h3, 8'h03);
    wr(3'h7, 8'h5a);
    i_aen_n <= 1'b1;
    wr(3'h7, 8'hff);
    i_aen_n <= 1'b0;
    rc(3'h7, 8'h5a, "scratch");
    $display("test register map done");
    for (i = 0; i < 8; i = i + 1) begin
      fmt = FMTS[63-8*i -: 8];
      nb = 5 + fmt[1:0];
      wr(3'h3, fmt);
      rc(3'h3, fmt, "format readback");
      nbits <= nb;
      par_en <= fmt[3];
      n0 = uart_serial_peer_i.nfr;
      wr(3'h0, 8'ha5);
      wr(3'h0, 8'h5a);
      k = 0;
      while (uart_serial_peer_i.nfr < n0 + 2 && k < 2000) begin
        @(posedge i_ref_clk);
        k = k + 1;
      end
      if (k >= 2000) begin
        chk("frame wait", 1'b0, 1'b1);
        wrap_up;
      end
      d = 8'h5a & (8'hff >> (3 - fmt[1:0]));
      per = 16 * (1 + nb + fmt[3]) + (!fmt[2] ? 16 : (nb == 5 ? 24 : 32));
      chk("tx data", uart_serial_peer_i.got_data, d);
      if (fmt[3]) chk("tx parity", uart_serial_peer_i.got_par,
        fmt[5] ? !fmt[4] : (fmt[4] ? ^d : ~^d));
      chk("frame period", uart_serial_peer_i.t_start -
        uart_serial_peer_i.t_prev, per);
    end
    $display("test transmit formats done");
    // the last frame may still be in its stop time: wait for empty
    k = 0;
    rd(3'h5, v);
    while (!v[6] && k < 100) begin
      rd(3'h5, v);
      k = k + 1;
    end
    chk("empty before break", v[6], 1'b1);
    if (!v[6]) wrap_up;
    wr(3'h3, 8'h43);
    wr(3'h0, 8'h96);
    k = 0;
    repeat (300) begin
      @(posedge i_ref_clk); #1;
      if (o_serial_output_pin !== 1'b0) k = k + 1;
    end
    chk("break pin", k, 0);
    rc(3'h5, 8'h60, "empty after break char");
    wr(3'h3, 8'h03);
    repeat (3) @(posedge i_ref_clk);
    chk("released pin", o_serial_output_pin, 1'b1);
    $display("test break done");
    wr(3'h3, 8'h1b);
    uart_serial_peer_i.send(8'h3c, 8, 1'b1, 1'b0);
    rc(3'h5, 8'h61, "rx ready");
    rc(3'h0, 8'h3c, "rx data");
    uart_serial_peer_i.send(8'h3c, 8, 1'b1, 1'b1);
    rc(3'h5, 8'h65, "rx parity error");
    rd(3'h0, v);
    wr(3'h3, 8'h2e);
    uart_serial_peer_i.send(8'h55, 7, 1'b1, 1'b1);
    rd(3'h0, v);
    chk("rx seven bits", v & 8'h7f, 8'h55);
    rc(3'h5, 8'h60, "mark one stop");
    $display("test receive done");
    wrap_up;
  end
endmodule // tb_uart_line_format
bind uart_line_format uart_line_format_checker uart_line_format_checker_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_aen_n(i_aen_n),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .i_serial_in(i_serial_in),
  .o_serial_output_pin(o_serial_output_pin),
  .o_baud_clock_output(o_baud_clock_output));

// ===== uart_fmt_map.vh
`ifndef UART_FMT_MAP_VH
`define UART_FMT_MAP_VH
// register offsets on the three address lines
`define OFS_DATA      3'h0
`define OFS_IEN       3'h1
`define OFS_IID       3'h2
`define OFS_LINE_CTL  3'h3
`define OFS_MODEM_CTL 3'h4
`define OFS_LINE_STAT 3'h5
`define OFS_MODEM_STAT 3'h6
`define OFS_SCRATCH   3'h7
// line format control field positions
`define LFC_WLEN_LO   0
`define LFC_WLEN_HI   1
`define LFC_STOP      2
`define LFC_PAR_EN    3
`define LFC_PAR_EVEN  4
`define LFC_PAR_STICK 5
`define LFC_BREAK     6
`define LFC_DIV_SEL   7
// line status field positions
`define LST_DATA_RDY  0
`define LST_OVERRUN   1
`define LST_PAR_ERR   2
`define LST_FRAME_ERR 3
`define LST_HOLD_EMPTY 5
`define LST_TX_EMPTY  6
// reset values
`define RST_ZERO      8'h00
`define RST_IID       8'h01
`define RST_DIVISOR   16'h0001
// oversampling ratio of the baud tick
`define OVERSAMPLE    5'h10
`define HALF_SAMPLE   5'h08
// stop time in ticks: one, one and a half, two bits
`define STOP_ONE      6'h10
`define STOP_ONE_HALF 6'h18
`define STOP_TWO      6'h20
`endif

// ===== uart_line_format.v
`timescale 1ns/10ps
`include "uart_fmt_map.vh"
module uart_line_format #(
  parameter DIV_W = 16
) (
  input  wire       i_ref_clk,  // device clock, 40 MHz
  input  wire       i_rst,      // sync reset, high
  input  wire       i_aen_n,    // address enable, low decodes
  input  wire [2:0] i_addr,     // register offset
  input  wire       i_rd,       // read strobe, one cycle
  input  wire       i_wr,       // write strobe, one cycle
  input  wire [7:0] i_wdata,    // write data
  output reg  [7:0] o_rdata,    // read data, valid cycle after i_rd
  input  wire       i_serial_in, // serial receive line
  output reg        o_serial_output_pin, // serial transmit line
  output reg        o_baud_clock_output  // 16x baud clock while divisor select is set (sits high at divisor one), held low otherwise
);
  localparam TX_IDLE = 3'd0, TX_START = 3'd1, TX_DATA = 3'd2;
  localparam TX_PAR = 3'd3, TX_STOP = 3'd4;
  localparam RX_IDLE = 2'd0, RX_START = 2'd1, RX_DATA = 2'd2;
  localparam RX_PAR = 2'd3;

  reg  [7:0]       line_format_control_reg;
  reg  [7:0]       interrupt_enable_reg;
  reg  [7:0]       fifo_control_reg;
  reg  [7:0]       modem_control_reg;
  reg  [7:0]       scratch_pad_reg;
  reg  [DIV_W-1:0] divisor_reg;
  reg  [DIV_W-1:0] baud_cnt_reg;
  reg              tick_reg;
  reg  [7:0]       receive_buffer_reg;
  reg              data_rdy_reg, overrun_reg, par_err_reg, frame_err_reg;
  reg  [2:0]       tx_state_reg;
  reg  [4:0]       tx_sub_reg;
  reg  [5:0]       tx_stop_len_reg;
  reg  [2:0]       tx_bit_reg;
  reg  [7:0]       tx_shift_reg;
  reg              tx_par_reg;
  reg              tx_line_reg;
  reg  [1:0]       rx_state_reg;
  reg              rx_stop_ph_reg;
  reg  [4:0]       rx_sub_reg;
  reg  [2:0]       rx_bit_reg;
  reg  [7:0]       rx_shift_reg;
  reg              rx_par_reg;
  reg              rx_prev_reg;
  wire             div_sel = line_format_control_reg[`LFC_DIV_SEL];
  wire [2:0]       last_bit = {1'b1, line_format_control_reg[1:0]};
  wire             par_en = line_format_control_reg[`LFC_PAR_EN];
  wire             par_even = line_format_control_reg[`LFC_PAR_EVEN];
  wire             par_stick = line_format_control_reg[`LFC_PAR_STICK];
  wire             sel = ~i_aen_n;
  wire             buf_in_ready, buf_out_valid;
  wire [7:0]       buf_out_data;
  wire             buf_take = (tx_state_reg == TX_IDLE) & tick_reg;
  wire             hold_empty = buf_in_ready;
  wire             tx_empty = hold_empty & ~buf_out_valid &
                              (tx_state_reg == TX_IDLE);
  // expected parity: stick forces value, else odd/even over data
  wire [7:0]       rx_masked = rx_shift_reg &
                               ~(8'hff << ({1'b0, last_bit} + 4'd1));
  wire             rx_par_exp = par_stick ? ~par_even :
                                (^rx_masked) ^ ~par_even;
  wire [7:0]       lstat = {1'b0, tx_empty, hold_empty, 1'b0, frame_err_reg,
                            par_err_reg, overrun_reg, data_rdy_reg};
  wire             hold_wr = sel & i_wr & (i_addr == `OFS_DATA) & ~div_sel;

  // transmit holding word waits here; writes while full are dropped
  uart_skid_buf #(.WIDTH(8)) u_hold (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (hold_wr),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (i_wdata),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_take),
    .o_out_data  (buf_out_data)
  );

  // register writes, decoded only with address enable low
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      line_format_control_reg <= `RST_ZERO;
      interrupt_enable_reg    <= `RST_ZERO;
      fifo_control_reg        <= `RST_ZERO;
      modem_control_reg       <= `RST_ZERO;
      scratch_pad_reg         <= `RST_ZERO;
      divisor_reg             <= `RST_DIVISOR;
    end else if (sel & i_wr) begin
      if (i_addr == `OFS_DATA && div_sel)
        divisor_reg[7:0] <= i_wdata;
      else if (i_addr == `OFS_IEN && div_sel)
        divisor_reg[15:8] <= i_wdata;
      else if (i_addr == `OFS_IEN)
        interrupt_enable_reg <= {4'h0, i_wdata[3:0]};
      else if (i_addr == `OFS_IID)
        fifo_control_reg <= i_wdata;
      else if (i_addr == `OFS_LINE_CTL)
        line_format_control_reg <= i_wdata;
      else if (i_addr == `OFS_MODEM_CTL)
        modem_control_reg <= {3'h0, i_wdata[4:0]};
      else if (i_addr == `OFS_SCRATCH)
        scratch_pad_reg <= i_wdata;
    end
  end

  // read mux; receive read clears data ready, status read clears errors
  always @(posedge i_ref_clk) begin
    if (i_rst)
      o_rdata <= `RST_ZERO;
    else if (sel & i_rd) begin
      if (i_addr == `OFS_DATA && div_sel)
        o_rdata <= divisor_reg[7:0];
      else if (i_addr == `OFS_DATA)
        o_rdata <= receive_buffer_reg;
      else if (i_addr == `OFS_IEN && div_sel)
        o_rdata <= divisor_reg[15:8];
      else if (i_addr == `OFS_IEN)
        o_rdata <= interrupt_enable_reg;
      else if (i_addr == `OFS_IID)
        o_rdata <= `RST_IID;
      else if (i_addr == `OFS_LINE_CTL)
        o_rdata <= line_format_control_reg;
      else if (i_addr == `OFS_MODEM_CTL)
        o_rdata <= modem_control_reg;
      else if (i_addr == `OFS_LINE_STAT)
        o_rdata <= lstat;
      else if (i_addr == `OFS_MODEM_STAT)
        o_rdata <= `RST_ZERO;
      else
        o_rdata <= scratch_pad_reg;
    end
  end

  // baud divider gives a one-cycle 16x tick; load on divisor write
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      baud_cnt_reg <= `RST_DIVISOR;
      tick_reg     <= 1'b0;
      o_baud_clock_output <= 1'b0;
    end else begin
      if (sel & i_wr & div_sel & (i_addr[2:1] == 2'b00)) begin
        // counter restarts from the divisor as it is being written
        baud_cnt_reg <= i_addr[0] ? {i_wdata, divisor_reg[7:0]} :
                                    {divisor_reg[15:8], i_wdata};
        tick_reg     <= 1'b0;
      end else if (baud_cnt_reg <= 16'h0001) begin
        baud_cnt_reg <= divisor_reg;
        tick_reg     <= 1'b1;
      end else begin
        baud_cnt_reg <= baud_cnt_reg - 16'h0001;
        tick_reg     <= 1'b0;
      end
      // pin shows the tick only while divisor select is set;
      // at divisor one the counter never moves, so the pin sits high
      o_baud_clock_output <= div_sel &
                             (baud_cnt_reg > (divisor_reg >> 1));
    end
  end

  // transmitter; start, data and parity bits last 16 ticks each, stop length set on load
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      tx_state_reg    <= TX_IDLE;
      tx_sub_reg      <= 5'h00;
      tx_stop_len_reg <= `STOP_ONE;
      tx_bit_reg      <= 3'd0;
      tx_shift_reg    <= 8'h00;
      tx_par_reg      <= 1'b0;
      tx_line_reg     <= 1'b1;
    end else if (tick_reg) begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_line_reg <= 1'b1;
          if (buf_out_valid) begin
            tx_shift_reg <= buf_out_data;
            tx_par_reg   <= par_stick ? ~par_even :
                            (^(buf_out_data &
                               ~(8'hff << ({1'b0, last_bit} + 4'd1))))
                            ^ ~par_even;
            tx_line_reg  <= 1'b0;
            tx_sub_reg   <= 5'h00;
            tx_state_reg <= TX_START;
          end
          // 16, 24 or 32 ticks of stop time
          if (!line_format_control_reg[`LFC_STOP])
            tx_stop_len_reg <= `STOP_ONE;
          else if (line_format_control_reg[1:0] == 2'b00)
            tx_stop_len_reg <= `STOP_ONE_HALF;
          else
            tx_stop_len_reg <= `STOP_TWO;
        end
        TX_START, TX_DATA, TX_PAR: begin
          if (tx_sub_reg == `OVERSAMPLE - 5'h01) begin
            tx_sub_reg <= 5'h00;
            if (tx_state_reg == TX_START) begin
              tx_state_reg <= TX_DATA;
              tx_bit_reg   <= 3'd0;
              tx_line_reg  <= tx_shift_reg[0];
            end else if (tx_state_reg == TX_DATA && tx_bit_reg != last_bit)
            begin
              tx_bit_reg   <= tx_bit_reg + 3'd1;
              tx_line_reg  <= tx_shift_reg[tx_bit_reg + 3'd1];
            end else if (tx_state_reg == TX_DATA && par_en) begin
              tx_state_reg <= TX_PAR;
              tx_line_reg  <= tx_par_reg;
            end else begin
              tx_state_reg <= TX_STOP;
              tx_line_reg  <= 1'b1;
            end
          end else
            tx_sub_reg <= tx_sub_reg + 5'h01;
        end
        default: begin
          // the idle tick before the next start is the last stop tick
          if ({1'b0, tx_sub_reg} == tx_stop_len_reg - 6'h02) begin
            tx_sub_reg   <= 5'h00;
            tx_state_reg <= TX_IDLE;
          end else
            tx_sub_reg <= tx_sub_reg + 5'h01;
        end
      endcase
    end
  end

  // break forces only the pin low; the shifter above runs on
  always @(posedge i_ref_clk) begin
    if (i_rst)
      o_serial_output_pin <= 1'b1;
    else
      o_serial_output_pin <= tx_line_reg &
                             ~line_format_control_reg[`LFC_BREAK];
  end

  // receiver samples mid-bit; data ready set wins over read clear
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      rx_state_reg   <= RX_IDLE;
      rx_stop_ph_reg <= 1'b0;
      rx_sub_reg     <= 5'h00;
      rx_bit_reg     <= 3'd0;
      rx_shift_reg   <= 8'h00;
      rx_par_reg     <= 1'b0;
      rx_prev_reg    <= 1'b1;
      receive_buffer_reg <= 8'h00;
      data_rdy_reg   <= 1'b0;
      overrun_reg    <= 1'b0;
      par_err_reg    <= 1'b0;
      frame_err_reg  <= 1'b0;
    end else begin
      if (sel & i_rd & (i_addr == `OFS_DATA) & ~div_sel)
        data_rdy_reg <= 1'b0;
      if (sel & i_rd & (i_addr == `OFS_LINE_STAT)) begin
        overrun_reg   <= 1'b0;
        par_err_reg   <= 1'b0;
        frame_err_reg <= 1'b0;
      end
      if (tick_reg) begin
        rx_prev_reg <= i_serial_in;
        rx_sub_reg  <= rx_sub_reg + 5'h01;
        case (rx_state_reg)
          RX_IDLE: begin
            if (rx_prev_reg & ~i_serial_in) begin
              rx_state_reg <= RX_START;
              rx_sub_reg   <= 5'h01;
            end
          end
          RX_START: begin
            if (rx_sub_reg == `HALF_SAMPLE - 5'h01) begin
              rx_sub_reg   <= 5'h00;
              rx_bit_reg   <= 3'd0;
              rx_shift_reg <= 8'h00;
              rx_stop_ph_reg <= 1'b0;
              rx_state_reg <= i_serial_in ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (rx_sub_reg == `OVERSAMPLE - 5'h01) begin
              rx_sub_reg <= 5'h00;
              if (rx_stop_ph_reg) begin
                // only the first stop bit is looked at
                rx_state_reg  <= RX_IDLE;
                receive_buffer_reg <= rx_shift_reg;
                data_rdy_reg  <= 1'b1;
                // error flags stick until the status read; set wins
                if (data_rdy_reg)
                  overrun_reg <= 1'b1;
                if (!i_serial_in)
                  frame_err_reg <= 1'b1;
                if (par_en && (rx_par_reg != rx_par_exp))
                  par_err_reg <= 1'b1;
              end else begin
                rx_shift_reg[rx_bit_reg] <= i_serial_in;
                if (rx_bit_reg == last_bit) begin
                  if (par_en)
                    rx_state_reg <= RX_PAR;
                  else
                    rx_stop_ph_reg <= 1'b1;
                end else
                  rx_bit_reg <= rx_bit_reg + 3'd1;
              end
            end
          end
          default: begin
            if (rx_sub_reg == `OVERSAMPLE - 5'h01) begin
              rx_sub_reg     <= 5'h00;
              rx_par_reg     <= i_serial_in;
              rx_stop_ph_reg <= 1'b1;
              rx_state_reg   <= RX_DATA;
            end
          end
        endcase
      end
    end
  end
endmodule // uart_line_format

// ===== uart_line_format_checker.sv
`timescale 1ns/10ps
module uart_line_format_checker (
  input wire       i_ref_clk,           // device clock
  input wire       i_rst,               // sync reset
  input wire       i_aen_n,             // address enable
  input wire [2:0] i_addr,              // offset
  input wire       i_rd,                // read strobe
  input wire       i_wr,                // write strobe
  input wire [7:0] i_wdata,             // write data
  input wire [7:0] o_rdata,             // read data
  input wire       i_serial_in,         // rx line
  input wire       o_serial_output_pin, // tx line
  input wire       o_baud_clock_output  // baud clock
);
  reg  [7:0]  fmt_shadow_reg;
  reg  [7:0]  scratch_shadow_reg;
  reg  [7:0]  div_lo_shadow_reg;
  reg  [7:0]  div_hi_shadow_reg;
  wire        wr_ok    = i_wr && !i_aen_n;
  wire        rd_ok    = i_rd && !i_aen_n;
  wire [15:0] div_word = {div_hi_shadow_reg, div_lo_shadow_reg};
  wire        div_one  = (div_word == 16'h0001);
  // the pin can only toggle once the divisor is two or more
  wire        div_two  = (div_word == 16'h0002);
  // shadow copies of host writes, so reads can be predicted
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      fmt_shadow_reg     <= 8'h00;
      scratch_shadow_reg <= 8'h00;
      div_lo_shadow_reg  <= 8'h01;
      div_hi_shadow_reg  <= 8'h00;
    end else if (wr_ok) begin
      if (i_addr == 3'h3)
        fmt_shadow_reg <= i_wdata;
      if (i_addr == 3'h7)
        scratch_shadow_reg <= i_wdata;
      if (i_addr == 3'h0 && fmt_shadow_reg[7])
        div_lo_shadow_reg <= i_wdata;
      if (i_addr == 3'h1 && fmt_shadow_reg[7])
        div_hi_shadow_reg <= i_wdata;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  break_holds_low_a: assert property (fmt_shadow_reg[6]
    && $past(fmt_shadow_reg[6]) |-> !o_serial_output_pin)
    else $error("pin high during break");
  baud_gated_a: assert property (!fmt_shadow_reg[7]
    && !$past(fmt_shadow_reg[7]) |-> !o_baud_clock_output)
    else $error("baud out without select");
  baud_runs_a: assert property (fmt_shadow_reg[7] && div_two
    |-> ##[1:40] $changed(o_baud_clock_output)) else $error("baud idle");
  fmt_readback_a: assert property (rd_ok && i_addr == 3'h3
    |=> o_rdata == $past(fmt_shadow_reg)) else $error("line format read");
  scratch_read_a: assert property (rd_ok && i_addr == 3'h7
    |=> o_rdata == $past(scratch_shadow_reg)) else $error("scratch read");
  ident_fixed_a: assert property (rd_ok && i_addr == 3'h2
    |=> o_rdata == 8'h01) else $error("ident read");
  divisor_read_a: assert property (rd_ok && i_addr == 3'h0
    && fmt_shadow_reg[7] |=> o_rdata == $past(div_lo_shadow_reg))
    else $error("divisor read");
  divisor_high_a: assert property (rd_ok && i_addr == 3'h1
    && fmt_shadow_reg[7] |=> o_rdata == $past(div_hi_shadow_reg))
    else $error("divisor high read");
  read_ignored_a: assert property (!rd_ok
    |=> $stable(o_rdata)) else $error("read data moved");
  start_bit_a: assert property ($fell(o_serial_output_pin)
    && !fmt_shadow_reg[6] && div_one
    |-> !o_serial_output_pin[*8] ##1 !o_serial_output_pin[*8])
    else $error("short start bit");
endmodule // uart_line_format_checker

// ===== uart_serial_peer.sv
`timescale 1ns/10ps
module uart_serial_peer (
  input  wire       i_ref_clk, // device clock
  input  wire       i_line,    // line from device
  output reg        o_line,    // line to device
  input  wire [3:0] i_nbits,   // data bits per char
  input  wire       i_par_en   // parity bit present
);
  reg     [7:0] got_data;
  reg           got_par;
  integer       cyc;
  integer       t_start;
  integer       t_prev;
  integer       nfr;
  integer       j;
  // free cycle count, used to time frame starts
  always @(posedge i_ref_clk) cyc <= cyc + 1;
  // capture frames: sync on fall, sample mid-bit
  initial begin
    o_line = 1'b1;
    cyc = 0;
    nfr = 0;
    t_start = 0;
    forever begin
      @(negedge i_line);
      t_prev = t_start;
      t_start = cyc;
      got_data = 8'h00;
      repeat (8) @(posedge i_ref_clk);
      for (j = 0; j < i_nbits; j = j + 1) begin
        repeat (16) @(posedge i_ref_clk);
        got_data[j] = i_line;
      end
      repeat (16) @(posedge i_ref_clk);
      got_par = i_line;
      if (i_par_en) repeat (16) @(posedge i_ref_clk);
      nfr = nfr + 1;
    end
  end
  // one bit time at divisor one
  task bit_out(input b);
    begin
      o_line <= b;
      repeat (16) @(posedge i_ref_clk);
    end
  endtask
  // send one frame with a single stop bit
  task send(input [7:0] d, input integer n, input pe, input pv);
    integer m;
    begin
      @(posedge i_ref_clk);
      bit_out(1'b0);
      for (m = 0; m < n; m = m + 1) bit_out(d[m]);
      if (pe) bit_out(pv);
      bit_out(1'b1);
    end
  endtask
endmodule // uart_serial_peer

// ===== uart_skid_buf.v
`timescale 1ns/10ps
// two-entry buffer between the holding register and the shifter
module uart_skid_buf #(
  parameter WIDTH = 8
) (
  input  wire             i_ref_clk,  // device clock
  input  wire             i_rst,      // sync reset, high
  input  wire             i_in_valid, // word offered
  output wire             o_in_ready, // room for a word
  input  wire [WIDTH-1:0] i_in_data,  // word in
  output wire             o_out_valid, // word available
  input  wire             i_out_ready, // consumer takes word
  output wire [WIDTH-1:0] o_out_data  // oldest word
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wr_ptr_reg;
  reg             rd_ptr_reg;
  reg [1:0]       count_reg;
  wire            push;
  wire            pop;

  // full and empty follow the count exactly
  assign o_in_ready  = (count_reg != 2'd2);
  assign o_out_valid = (count_reg != 2'd0);
  assign o_out_data  = mem_reg[rd_ptr_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop  = o_out_valid & i_out_ready;

  // storage and pointers
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
    end else begin
      if (push) begin
        mem_reg[wr_ptr_reg] <= i_in_data;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // uart_skid_buf
